/* File: hdl/lcsg_src_mux.sv */
// source multiplexer for one cell data input
`timescale 1ns/1ps

module lcsg_src_mux #(
  parameter int NUM_SRC = 64,
  parameter int SW = 6
) (
  // selection
  input wire logic [SW-1:0] sel,
  // candidate sources
  input wire logic [NUM_SRC-1:0] sources,
  // chosen level
  output logic chosen
);
  if (NUM_SRC < 1 || NUM_SRC > (1 << SW)) begin : g_bad_num_src
    $error("lcsg_src_mux: NUM_SRC out of range for selector width");
  end

  // codes past the last source read as low rather than wrapping
  wire logic in_range;
  assign in_range = (32'(sel) < NUM_SRC);
  assign chosen = in_range ? sources[sel] : 1'b0;
endmodule : lcsg_src_mux

/* File: hdl/lcsg_cell_front.sv */
// data 3 and 4 source selection and gate-1 term gating for one logic cell
//
// Overview of operation
// - six-bit field, low bits of data3 register, picks the third input's source
// - six-bit field, low bits of data4 register, picks the fourth input's source
// - selector bits 7-6 read as zero and ignore writes
// - fields set at power-on reset only, kept through all other resets
// - gate bit 7 gates fourth input true, bit 6 its inverted copy
// - gate bit 5 gates third input true, bit 4 its inverted copy
// - gate bit 3 gates second input true, bit 2 its inverted copy
// - gate bit 1 gates first input true, bit 0 its inverted copy
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

// kept in this file so that the package is always compiled before its users
package lcsg_pkg;
  // register map, indices on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_DATA3_SEL = 4'h0;
  localparam logic [3:0] OFF_DATA4_SEL = 4'h1;
  localparam logic [3:0] OFF_GATE1_EN = 4'h2;
  // register and field layout
  localparam int REG_W = 8;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 6;
  localparam int SEL_MSB = SEL_LSB + SEL_W - 1;
  localparam int NUM_DATA = 4;
  // gate-1 enable bit positions: true copy at 2k+1, inverted copy at 2k
  localparam int G1_IN4_TRUE = 7;
  localparam int G1_IN4_INV = 6;
  localparam int G1_IN3_TRUE = 5;
  localparam int G1_IN3_INV = 4;
  localparam int G1_IN2_TRUE = 3;
  localparam int G1_IN2_INV = 2;
  localparam int G1_IN1_TRUE = 1;
  localparam int G1_IN1_INV = 0;
  // power-on values stand in for the undefined contents after POR or BOR
  localparam logic [5:0] SEL_POR = 6'h00;
  localparam logic [7:0] GATE_POR = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam logic [1:0] SEL_UNUSED = 2'h0;
endpackage : lcsg_pkg

module lcsg_cell_front #(
  parameter int NUM_SRC = 64
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [lcsg_pkg::ADDR_W-1:0] addr,
  input wire logic [lcsg_pkg::REG_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [lcsg_pkg::REG_W-1:0] rdata,
  // cell signals
  input wire logic [NUM_SRC-1:0] sources,
  input wire logic cell_data1,
  input wire logic cell_data2,
  output logic cell_data3,
  output logic cell_data4,
  output logic gate_one_output
);
  // elaboration stops here rather than letting selector codes alias
  if (NUM_SRC < 1 || NUM_SRC > (1 << lcsg_pkg::SEL_W)) begin : g_bad_num_src
    $error("lcsg_cell_front: NUM_SRC does not fit the selector field");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic hit(input logic [lcsg_pkg::ADDR_W-1:0] a,
                               input logic [lcsg_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [lcsg_pkg::SEL_W-1:0] third_input_source_field;
  logic [lcsg_pkg::SEL_W-1:0] fourth_input_source_field;
  logic [lcsg_pkg::REG_W-1:0] gate1_term_enable;

  wire logic wr_sel3;
  wire logic wr_sel4;
  wire logic wr_gate;
  wire logic [lcsg_pkg::REG_W-1:0] data3_source_select;
  wire logic [lcsg_pkg::REG_W-1:0] data4_source_select;
  wire logic [lcsg_pkg::REG_W-1:0] next_rdata;

  assign wr_sel3 = wr && hit(addr, lcsg_pkg::OFF_DATA3_SEL);
  assign wr_sel4 = wr && hit(addr, lcsg_pkg::OFF_DATA4_SEL);
  assign wr_gate = wr && hit(addr, lcsg_pkg::OFF_GATE1_EN);

  // upper two bits have no storage, so they read back as zero
  assign data3_source_select = {lcsg_pkg::SEL_UNUSED, third_input_source_field};
  assign data4_source_select = {lcsg_pkg::SEL_UNUSED, fourth_input_source_field};

  assign next_rdata = !rd ? lcsg_pkg::READ_NONE :
                      hit(addr, lcsg_pkg::OFF_DATA3_SEL) ? data3_source_select :
                      hit(addr, lcsg_pkg::OFF_DATA4_SEL) ? data4_source_select :
                      hit(addr, lcsg_pkg::OFF_GATE1_EN) ? gate1_term_enable :
                      lcsg_pkg::READ_NONE;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration storage

  // rst_n is the power-on/brown-out reset; no other reset reaches these fields
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      third_input_source_field <= lcsg_pkg::SEL_POR;
    end else if (wr_sel3) begin
      third_input_source_field <= wdata[lcsg_pkg::SEL_MSB:lcsg_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fourth_input_source_field <= lcsg_pkg::SEL_POR;
    end else if (wr_sel4) begin
      fourth_input_source_field <= wdata[lcsg_pkg::SEL_MSB:lcsg_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate1_term_enable <= lcsg_pkg::GATE_POR;
    end else if (wr_gate) begin
      gate1_term_enable <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= lcsg_pkg::READ_NONE;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source selection

  wire logic next_data3;
  wire logic next_data4;

  lcsg_src_mux #(
    .NUM_SRC(NUM_SRC),
    .SW(lcsg_pkg::SEL_W)
  ) u_mux3 (
    .sel(third_input_source_field),
    .sources(sources),
    .chosen(next_data3)
  );

  lcsg_src_mux #(
    .NUM_SRC(NUM_SRC),
    .SW(lcsg_pkg::SEL_W)
  ) u_mux4 (
    .sel(fourth_input_source_field),
    .sources(sources),
    .chosen(next_data4)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // gate 1 term gating

  // data k sits at vector position k-1; its enables at 2(k-1)+1 and 2(k-1)
  wire logic [lcsg_pkg::NUM_DATA-1:0] next_data;
  wire logic [lcsg_pkg::NUM_DATA-1:0] true_term;
  wire logic [lcsg_pkg::NUM_DATA-1:0] inv_term;
  wire logic next_gate;

  assign next_data = {next_data4, next_data3, cell_data2, cell_data1};

  genvar k;
  generate
    for (k = 0; k < lcsg_pkg::NUM_DATA; k++) begin : g_term
      assign true_term[k] = gate1_term_enable[2*k+1] & next_data[k];
      assign inv_term[k] = gate1_term_enable[2*k] & ~next_data[k];
    end
  endgenerate

  // an empty enable set gives zero; polarity is applied further on in the cell
  assign next_gate = |{true_term, inv_term};

  // all three outputs are registered, so they move together one edge after the inputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cell_data3 <= 1'b0;
      cell_data4 <= 1'b0;
      gate_one_output <= 1'b0;
    end else begin
      cell_data3 <= next_data3;
      cell_data4 <= next_data4;
      gate_one_output <= next_gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_sel3_write_lands: assert property (
    wr_sel3 |=> third_input_source_field == $past(wdata[lcsg_pkg::SEL_MSB:lcsg_pkg::SEL_LSB])
  ) else $error("data3 selector did not take the written value");

  a_sel4_write_lands: assert property (
    wr_sel4 |=> fourth_input_source_field == $past(wdata[lcsg_pkg::SEL_MSB:lcsg_pkg::SEL_LSB])
  ) else $error("data4 selector did not take the written value");

  a_upper_read_zero: assert property (
    rd && (hit(addr, lcsg_pkg::OFF_DATA3_SEL) || hit(addr, lcsg_pkg::OFF_DATA4_SEL))
    |=> rdata[lcsg_pkg::REG_W-1:lcsg_pkg::SEL_W] == lcsg_pkg::SEL_UNUSED
  ) else $error("unimplemented selector bits read nonzero");

  a_config_holds: assert property (
    !wr |=> $stable(gate1_term_enable) && $stable(third_input_source_field)
            && $stable(fourth_input_source_field)
  ) else $error("configuration changed without a write");

  a_in4_true_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN4_TRUE] && next_data4 |=> gate_one_output
  ) else $error("enabled true data4 term missing from gate 1");

  a_in3_inv_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN3_INV] && !next_data3 |=> gate_one_output
  ) else $error("enabled inverted data3 term missing from gate 1");

  a_in2_inv_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN2_INV] && !cell_data2 |=> gate_one_output
  ) else $error("enabled inverted data2 term missing from gate 1");

  a_in1_true_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN1_TRUE] && cell_data1 |=> gate_one_output
  ) else $error("enabled true data1 term missing from gate 1");

  a_none_zero_gate: assert property (
    gate1_term_enable == '0 |=> !gate_one_output
  ) else $error("gate 1 high with no term enabled");

  a_gate_read_back: assert property (
    rd && hit(addr, lcsg_pkg::OFF_GATE1_EN) && !wr |=> rdata == $past(gate1_term_enable)
  ) else $error("gate enable read back wrong");

  a_in4_inv_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN4_INV] && !next_data4 |=> gate_one_output
  ) else $error("enabled inverted data4 term missing from gate 1");

  a_in3_true_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN3_TRUE] && next_data3 |=> gate_one_output
  ) else $error("enabled true data3 term missing from gate 1");

  a_in2_true_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN2_TRUE] && cell_data2 |=> gate_one_output
  ) else $error("enabled true data2 term missing from gate 1");

  a_in1_inv_gate: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN1_INV] && !cell_data1 |=> gate_one_output
  ) else $error("enabled inverted data1 term missing from gate 1");

  // a lone enable must not let its unselected twin through
  a_in4_inv_excluded: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN4_TRUE] && $countones(gate1_term_enable) == 1
    && !next_data4 |=> !gate_one_output
  ) else $error("excluded inverted data4 term reached gate 1");

  a_in1_true_excluded: assert property (
    gate1_term_enable[lcsg_pkg::G1_IN1_INV] && $countones(gate1_term_enable) == 1
    && cell_data1 |=> !gate_one_output
  ) else $error("excluded true data1 term reached gate 1");

  a_data3_follows: assert property (
    32'(third_input_source_field) < NUM_SRC
    |=> cell_data3 == $past(sources[third_input_source_field])
  ) else $error("data3 does not follow its selected source");

  a_data4_follows: assert property (
    32'(fourth_input_source_field) < NUM_SRC
    |=> cell_data4 == $past(sources[fourth_input_source_field])
  ) else $error("data4 does not follow its selected source");

  a_sel3_read_back: assert property (
    rd && hit(addr, lcsg_pkg::OFF_DATA3_SEL)
    |=> rdata[lcsg_pkg::SEL_MSB:lcsg_pkg::SEL_LSB] == $past(third_input_source_field)
  ) else $error("data3 selector read back wrong");

  a_sel4_read_back: assert property (
    rd && hit(addr, lcsg_pkg::OFF_DATA4_SEL)
    |=> rdata[lcsg_pkg::SEL_MSB:lcsg_pkg::SEL_LSB] == $past(fourth_input_source_field)
  ) else $error("data4 selector read back wrong");

  a_rdata_idle_zero: assert property (
    !rd |=> rdata == lcsg_pkg::READ_NONE
  ) else $error("read data present without a read");

  a_unmapped_read_zero: assert property (
    rd && !hit(addr, lcsg_pkg::OFF_DATA3_SEL) && !hit(addr, lcsg_pkg::OFF_DATA4_SEL)
    && !hit(addr, lcsg_pkg::OFF_GATE1_EN)
    |=> rdata == lcsg_pkg::READ_NONE
  ) else $error("unmapped index read nonzero");

  c_sel3_written: cover property (wr_sel3 ##1 rd && hit(addr, lcsg_pkg::OFF_DATA3_SEL));
  c_sel4_chosen: cover property (wr_sel4 ##[1:4] cell_data4);
  c_gate_high: cover property (!gate_one_output ##1 gate_one_output);
  c_all_terms: cover property (gate1_term_enable == 8'hFF ##1 gate_one_output);
endmodule : lcsg_cell_front

/* File: bench/lcsg_src_model.sv */
// partner model: on-chip source levels feeding the cell
`timescale 1ns/1ps

module lcsg_src_model #(
  parameter int NUM_SRC = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // levels requested by the scenario
  input wire logic [NUM_SRC-1:0] want_sources,
  input wire logic [1:0] want_data,
  // levels presented to the cell
  output logic [NUM_SRC-1:0] sources,
  output logic cell_data1,
  output logic cell_data2
);
  // peripheral outputs move only on the device clock, as they do on chip
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sources <= '0;
      cell_data1 <= 1'b0;
      cell_data2 <= 1'b0;
    end else begin
      sources <= want_sources;
      cell_data1 <= want_data[0];
      cell_data2 <= want_data[1];
    end
  end
endmodule : lcsg_src_model

/* File: bench/lcsg_cell_front_tb_top.sv */
// testbench for the cell input selector and gate-1 term gating
`timescale 1ns/1ps

module lcsg_cell_front_tb_top;
  logic mclk, rst_n, wr, rd;
  logic [lcsg_pkg::ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata;
  logic [63:0] want_sources, sources;
  logic [1:0] want_data;
  logic cell_data1, cell_data2, cell_data3, cell_data4, gate_one_output;
  int miscompares, checks_done;

  lcsg_src_model #(.NUM_SRC(64)) lcsg_src_model_i (.mclk(mclk), .rst_n(rst_n),
    .want_sources(want_sources), .want_data(want_data), .sources(sources),
    .cell_data1(cell_data1), .cell_data2(cell_data2));
  lcsg_cell_front #(.NUM_SRC(64)) lcsg_cell_front_i (.mclk(mclk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sources(sources),
    .cell_data1(cell_data1), .cell_data2(cell_data2), .cell_data3(cell_data3),
    .cell_data4(cell_data4), .gate_one_output(gate_one_output));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check1

  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_write

  // rdata stands only in the cycle after the read strobe
  task automatic read_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check8(rdata, exp, "register read");
  endtask : read_check

  // one edge for the source model, one for the cell registers
  task automatic drive(input logic [63:0] s, input logic [1:0] dd);
    @(posedge mclk);
    want_sources <= s;
    want_data <= dd;
    repeat (2) @(posedge mclk);
    #1;
  endtask : drive

  function automatic logic gate_exp(input logic [7:0] en, input logic [3:0] d);
    return |(en & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
  endfunction : gate_exp

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    int i;
    logic [7:0] en;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    want_sources = '0;
    want_data = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    read_check(lcsg_pkg::OFF_DATA3_SEL, {lcsg_pkg::SEL_UNUSED, lcsg_pkg::SEL_POR});
    read_check(lcsg_pkg::OFF_DATA4_SEL, {lcsg_pkg::SEL_UNUSED, lcsg_pkg::SEL_POR});
    read_check(lcsg_pkg::OFF_GATE1_EN, lcsg_pkg::GATE_POR);
    $display("test reset values done");
    // unmapped write must not land in any register
    reg_write(lcsg_pkg::OFF_DATA3_SEL, 8'hFF);
    reg_write(lcsg_pkg::OFF_DATA4_SEL, 8'hC5);
    reg_write(4'hF, 8'hAA);
    read_check(lcsg_pkg::OFF_DATA3_SEL, 8'h3F);
    read_check(lcsg_pkg::OFF_DATA4_SEL, 8'h05);
    read_check(lcsg_pkg::OFF_GATE1_EN, 8'h00);
    read_check(4'hF, 8'h00);
    $display("test register access done");
    for (int k = 0; k < 7; k++) begin
      i = (k == 6) ? 63 : (1 << k);
      reg_write(lcsg_pkg::OFF_DATA3_SEL, 8'(i));
      reg_write(lcsg_pkg::OFF_DATA4_SEL, 8'(63 - i));
      drive(64'h1 << i, 2'h0);
      check1(cell_data3, 1'b1, "data3 pick");
      check1(cell_data4, 1'b0, "data4 pick");
      drive(64'h1 << (63 - i), 2'h0);
      check1(cell_data3, 1'b0, "data3 pick");
      check1(cell_data4, 1'b1, "data4 pick");
    end
    $display("test source selection done");
    reg_write(lcsg_pkg::OFF_DATA3_SEL, 8'h00);
    reg_write(lcsg_pkg::OFF_DATA4_SEL, 8'h01);
    for (int e = 0; e < 10; e++) begin
      en = (e < 8) ? (8'h01 << e) : ((e == 8) ? 8'h00 : 8'hFF);
      reg_write(lcsg_pkg::OFF_GATE1_EN, en);
      read_check(lcsg_pkg::OFF_GATE1_EN, en);
      for (int d = 0; d < 16; d++) begin
        drive({62'h0, d[3], d[2]}, d[1:0]);
        check1(gate_one_output, gate_exp(en, 4'(d)), "gate one");
      end
    end
    $display("test gate terms done");
    tally_and_finish();
  end
endmodule : lcsg_cell_front_tb_top
